// >>> bfb_pkg.sv
/*
  constants, states and operation codes shared by the boot flash host
  controller and its bench.
  assumes one 40 MHz clock; all pin timing is counted in its cycles.
*/
package bfb_pkg;

  // ----------------------------------------------------------------
  // clock and array geometry
  // ----------------------------------------------------------------
  localparam int CLK_MHZ           = 40;     // system clock rate
  localparam int ADDR_W            = 21;     // word address width, largest density
  localparam int DATA_W            = 16;     // word-wide part, all data lines
  localparam int PARAM_BLOCKS      = 8;      // small parameter blocks
  localparam int PARAM_BLOCK_WORDS = 4096;   // words per parameter block
  localparam int MAIN_BLOCK_WORDS  = 32768;  // words per main block

  // ----------------------------------------------------------------
  // pin timing in ns (plain defaults) and derived cycle counts
  // ----------------------------------------------------------------
  localparam int RESET_LOW_WIDTH_NS     = 100;    // least reset low time
  localparam int RESET_TO_READ_VALID_NS = 150;    // release to first read
  localparam int RESET_TO_WRITE_WE_NS   = 100;    // release to write enable low
  localparam int RESET_TO_WRITE_CE_NS   = 100;    // release to chip select low
  localparam int ABORT_SHUTDOWN_TIME_NS = 20000;  // aborted operation shutdown
  localparam int READ_ACCESS_NS         = 100;    // select to data valid
  localparam int WRITE_PULSE_NS         = 50;     // write enable low width
  localparam int SETUP_NS               = 25;     // address/data to strobe
  localparam int SYNC_STAGES            = 2;      // data input synchroniser

  localparam int RESET_TO_WRITE_NS = (RESET_TO_WRITE_WE_NS > RESET_TO_WRITE_CE_NS) ?
                                     RESET_TO_WRITE_WE_NS : RESET_TO_WRITE_CE_NS;

  // least times round up to whole cycles
  localparam logic [11:0] RST_LOW_CYC = 12'((RESET_LOW_WIDTH_NS * CLK_MHZ + 999) / 1000);
  localparam logic [11:0] RD_REC_CYC  = 12'((RESET_TO_READ_VALID_NS * CLK_MHZ + 999) / 1000);
  localparam logic [11:0] WR_REC_CYC  = 12'((RESET_TO_WRITE_NS * CLK_MHZ + 999) / 1000);
  localparam logic [11:0] ABORT_CYC   = 12'((ABORT_SHUTDOWN_TIME_NS * CLK_MHZ + 999) / 1000);
  localparam logic [11:0] ACC_CYC     = 12'((READ_ACCESS_NS * CLK_MHZ + 999) / 1000 + SYNC_STAGES);
  localparam logic [11:0] WE_CYC      = 12'((WRITE_PULSE_NS * CLK_MHZ + 999) / 1000);
  localparam logic [11:0] SETUP_CYC   = 12'((SETUP_NS * CLK_MHZ + 999) / 1000);
  localparam logic [11:0] HOLD_CYC    = 12'h0001;  // data held past strobe rise
  localparam logic [11:0] CNT_MAX     = 12'hFFF;   // saturating helper count

  // ----------------------------------------------------------------
  // command codes and status layout
  // ----------------------------------------------------------------
  localparam logic [15:0] CMD_READ_ARRAY    = 16'h00FF;
  localparam logic [15:0] CMD_PROGRAM       = 16'h0040;
  localparam logic [15:0] CMD_ERASE         = 16'h0020;
  localparam logic [15:0] CMD_ERASE_CONFIRM = 16'h00D0;
  localparam int          STATUS_READY_BIT  = 7;
  localparam int          LOCK_FAIL_BIT     = 1;
  localparam int          PROGRAM_FAIL_BIT  = 4;
  localparam int          ERASE_FAIL_BIT    = 5;

  // ----------------------------------------------------------------
  // user operations and controller states
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    OP_READ    = 3'h0,  // array read, inserts read-array command if needed
    OP_STATUS  = 3'h1,  // plain read, no mode change
    OP_COMMAND = 3'h2,  // single write of user data
    OP_PROGRAM = 3'h3,  // set-up plus data write
    OP_ERASE   = 3'h4,  // set-up plus confirm write
    OP_RESET   = 3'h5   // reset/power-down pulse
  } bfb_op_type;

  // gray order along the access path idle-setup-pulse-hold
  typedef enum logic [2:0] {
    ST_IDLE    = 3'b000,
    ST_SETUP   = 3'b001,
    ST_PULSE   = 3'b011,
    ST_HOLD    = 3'b010,
    ST_RST_LOW = 3'b110
  } bfb_state_type;

endpackage

// >>> bfb_timer.sv
/*
  loadable countdown timer used for strobe widths and recovery waits.
  assumes load is a one-cycle pulse from logic on the same clock.
*/
`timescale 1ns/100ps
`default_nettype none
module bfb_timer #(
  parameter logic [11:0] RESET_VAL = 12'h000  // count held after reset
) (
  input  wire logic        clk_sys,
  input  wire logic        rst,
  input  wire logic        load,
  input  wire logic [11:0] load_val,
  output logic             zero
);

  typedef struct packed {
    logic [11:0] count;  // cycles still to run
  } bfb_tmr_state_type;

  bfb_tmr_state_type tmr_reg;
  bfb_tmr_state_type tmr_next;

  // ----------------------------------------------------------------
  // next count: load wins, otherwise run down and stop at zero
  // ----------------------------------------------------------------
  always_comb begin
    tmr_next = tmr_reg;
    if (load) begin
      tmr_next.count = load_val;
    end else if (tmr_reg.count != 12'h000) begin
      tmr_next.count = tmr_reg.count - 12'h001;
    end
    if (rst) begin
      tmr_next.count = RESET_VAL;
    end
  end

  always_ff @(posedge clk_sys) begin
    tmr_reg <= tmr_next;
  end

  assign zero = (tmr_reg.count == 12'h000);

endmodule
`default_nettype wire

// >>> bfb_ctrl.sv
/*
  host-side controller for a word-wide boot-block nor flash: turns user
  requests into read, write, program, erase and reset pin sequences.
  assumes flash pins are wired straight to the ports; dq is resolved
  outside from dq_out and dq_oe, and dq_in comes asynchronously.
*/
`timescale 1ns/100ps
`default_nettype none
module bfb_ctrl (
  input  wire logic                       clk_sys,
  input  wire logic                       rst,
  // user side
  input  wire logic                       req,
  input  wire bfb_pkg::bfb_op_type        op,
  input  wire logic [bfb_pkg::ADDR_W-1:0] addr,
  input  wire logic [bfb_pkg::DATA_W-1:0] wdata,
  output logic                            done,
  output logic [bfb_pkg::DATA_W-1:0]      rdata,
  output logic                            idle,
  output logic                            busy,
  // flash pins
  output logic                            reset_powerdown_n,
  output logic                            ce_n,
  output logic                            oe_n,
  output logic                            we_n,
  output logic                            wp_n,
  output logic [bfb_pkg::ADDR_W-1:0]      a_out,
  output logic [bfb_pkg::DATA_W-1:0]      dq_out,
  output logic                            dq_oe,
  input  wire logic [bfb_pkg::DATA_W-1:0] dq_in
);

  // ----------------------------------------------------------------
  // state record
  // ----------------------------------------------------------------
  typedef struct packed {
    bfb_pkg::bfb_state_type    state;       // pin sequencer state
    bfb_pkg::bfb_op_type       op;          // operation in progress
    logic                      second;      // second bus cycle running
    logic                      is_wr;       // current bus cycle is a write
    logic                      array_mode;  // flash known to be in read array
    logic                      busy;        // program or erase outstanding
    logic                      aborting;    // shutdown time still running
    logic                      rec_wait;    // recovery not yet started
    logic                      rec_ok;      // recovery timers started
    logic                      rp_n;        // reset/power-down pin
    logic                      ce_n;        // chip select pin
    logic                      oe_n;        // output enable pin
    logic                      we_n;        // write enable pin
    logic                      wp_n;        // write protect pin
    logic                      dq_oe;       // driving data pins
    logic                      done;        // request finished
    logic                      idle;        // ready for a request
    logic [15:0]               dq_out;      // data driven
    logic [15:0]               wdata;       // user data for second cycle
    logic [15:0]               rdata;       // captured read data
    logic [15:0]               dq_s1;       // synchroniser first stage
    logic [15:0]               dq_s2;       // synchroniser second stage
    logic [bfb_pkg::ADDR_W-1:0] a_out;      // address driven
  } bfb_ctrl_state_type;

  bfb_ctrl_state_type s_reg;
  bfb_ctrl_state_type s_next;

  logic        ph_load;     // phase timer load
  logic [11:0] ph_val;      // phase timer value
  logic        ph_zero;     // phase over
  logic        rec_load;    // start both recovery timers
  logic        rd_zero;     // read recovery over
  logic        wr_zero;     // write recovery over
  logic        abrt_load;   // start abort shutdown time
  logic        abrt_zero;   // abort shutdown over
  logic        need_wr;     // request begins with a write cycle
  logic        go;          // request taken this cycle

  // ----------------------------------------------------------------
  // timers: phase width, read and write recovery, abort shutdown
  // ----------------------------------------------------------------
  // phase timer starts loaded so reset is held its full width
  bfb_timer #(.RESET_VAL(bfb_pkg::RST_LOW_CYC)) u_ph (
    .clk_sys(clk_sys), .rst(rst), .load(ph_load), .load_val(ph_val), .zero(ph_zero));
  bfb_timer u_rd (
    .clk_sys(clk_sys), .rst(rst), .load(rec_load), .load_val(bfb_pkg::RD_REC_CYC), .zero(rd_zero));
  bfb_timer u_wr (
    .clk_sys(clk_sys), .rst(rst), .load(rec_load), .load_val(bfb_pkg::WR_REC_CYC), .zero(wr_zero));
  bfb_timer u_ab (
    .clk_sys(clk_sys), .rst(rst), .load(abrt_load), .load_val(bfb_pkg::ABORT_CYC), .zero(abrt_zero));

  // ----------------------------------------------------------------
  // request acceptance
  // ----------------------------------------------------------------
  // array reads outside array mode first write the read-array command
  always_comb begin
    need_wr = (op != bfb_pkg::OP_STATUS) && !((op == bfb_pkg::OP_READ) && s_reg.array_mode);
    go      = req && (s_reg.state == bfb_pkg::ST_IDLE) && s_reg.rec_ok && rd_zero
              && (!need_wr || wr_zero) && (op != bfb_pkg::OP_RESET);
  end

  // ----------------------------------------------------------------
  // sequencer
  // ----------------------------------------------------------------
  always_comb begin
    s_next    = s_reg;
    ph_load   = 1'b0;
    ph_val    = bfb_pkg::SETUP_CYC;
    rec_load  = 1'b0;
    abrt_load = 1'b0;
    s_next.done  = 1'b0;
    s_next.dq_s1 = dq_in;
    s_next.dq_s2 = s_reg.dq_s1;
    case (s_reg.state)
      bfb_pkg::ST_RST_LOW: begin
        // pin held low for the full width, then released
        if (ph_zero) begin
          s_next.rp_n  = 1'b1;
          s_next.state = bfb_pkg::ST_IDLE;
        end
      end
      bfb_pkg::ST_IDLE: begin
        // recovery counts from the later of release and shutdown end
        if (s_reg.rec_wait && abrt_zero && s_reg.rp_n) begin
          rec_load        = 1'b1;
          s_next.rec_wait = 1'b0;
          s_next.rec_ok   = 1'b1;
          s_next.aborting = 1'b0;
        end
        if (req && op == bfb_pkg::OP_RESET) begin
          // reset during program or erase aborts it
          if (s_reg.busy) begin
            abrt_load       = 1'b1;
            s_next.aborting = 1'b1;
          end
          s_next.rp_n       = 1'b0;
          s_next.rec_ok     = 1'b0;
          s_next.rec_wait   = 1'b1;
          s_next.busy       = 1'b0;
          s_next.wp_n       = 1'b0;
          s_next.array_mode = 1'b1;
          s_next.done       = 1'b1;
          s_next.state      = bfb_pkg::ST_RST_LOW;
          ph_load           = 1'b1;
          ph_val            = bfb_pkg::RST_LOW_CYC;
        end else if (go) begin
          s_next.op     = op;
          s_next.second = 1'b0;
          s_next.is_wr  = need_wr;
          s_next.a_out  = addr;
          s_next.wdata  = wdata;
          case (op)
            bfb_pkg::OP_PROGRAM: s_next.dq_out = bfb_pkg::CMD_PROGRAM;
            bfb_pkg::OP_ERASE:   s_next.dq_out = bfb_pkg::CMD_ERASE;
            bfb_pkg::OP_READ:    s_next.dq_out = bfb_pkg::CMD_READ_ARRAY;
            default:             s_next.dq_out = wdata;
          endcase
          // protect released before the operation and held through it
          if (op == bfb_pkg::OP_PROGRAM || op == bfb_pkg::OP_ERASE) begin
            s_next.wp_n = 1'b1;
          end
          s_next.state = bfb_pkg::ST_SETUP;
          ph_load      = 1'b1;
        end
      end
      bfb_pkg::ST_SETUP: begin
        // first select with address stable, then the write strobe; on reads output enable falls with select
        if (ph_zero) begin
          if (s_reg.ce_n) begin
            s_next.ce_n  = 1'b0;
            s_next.dq_oe = s_reg.is_wr;
            s_next.oe_n  = s_reg.is_wr;
            ph_load      = 1'b1;
            if (!s_reg.is_wr) begin
              ph_val       = bfb_pkg::ACC_CYC;
              s_next.state = bfb_pkg::ST_PULSE;
            end
          end else begin
            s_next.we_n  = 1'b0;
            s_next.state = bfb_pkg::ST_PULSE;
            ph_load      = 1'b1;
            ph_val       = bfb_pkg::WE_CYC;
          end
        end
      end
      bfb_pkg::ST_PULSE: begin
        // write enable rises before select so it marks the latch edge
        if (ph_zero) begin
          if (s_reg.is_wr) begin
            s_next.we_n = 1'b1;
          end else begin
            s_next.oe_n  = 1'b1;
            s_next.rdata = s_reg.dq_s2;
            // a ready status ends the outstanding operation
            if (s_reg.op == bfb_pkg::OP_STATUS && s_reg.dq_s2[bfb_pkg::STATUS_READY_BIT]) begin
              s_next.busy = 1'b0;
              s_next.wp_n = 1'b0;
            end
          end
          s_next.state = bfb_pkg::ST_HOLD;
          ph_load      = 1'b1;
          ph_val       = bfb_pkg::HOLD_CYC;
        end
      end
      bfb_pkg::ST_HOLD: begin
        if (ph_zero) begin
          s_next.ce_n  = 1'b1;
          s_next.dq_oe = 1'b0;
          ph_load      = 1'b1;
          if (s_reg.is_wr && s_reg.op == bfb_pkg::OP_COMMAND) begin
            s_next.array_mode = (s_reg.dq_out == bfb_pkg::CMD_READ_ARRAY);
          end
          if (!s_reg.second && s_reg.is_wr &&
              (s_reg.op == bfb_pkg::OP_PROGRAM || s_reg.op == bfb_pkg::OP_ERASE ||
               s_reg.op == bfb_pkg::OP_READ)) begin
            s_next.second = 1'b1;
            s_next.state  = bfb_pkg::ST_SETUP;
            case (s_reg.op)
              bfb_pkg::OP_PROGRAM: s_next.dq_out = s_reg.wdata;
              bfb_pkg::OP_ERASE:   s_next.dq_out = bfb_pkg::CMD_ERASE_CONFIRM;
              default: begin
                s_next.is_wr      = 1'b0;
                s_next.array_mode = 1'b1;
              end
            endcase
          end else begin
            if (s_reg.op == bfb_pkg::OP_PROGRAM || s_reg.op == bfb_pkg::OP_ERASE) begin
              s_next.busy       = 1'b1;
              s_next.array_mode = 1'b0;
            end
            s_next.done  = 1'b1;
            s_next.state = bfb_pkg::ST_IDLE;
          end
        end
      end
      default: begin
        s_next.state = bfb_pkg::ST_IDLE;
      end
    endcase
    s_next.idle = (s_next.state == bfb_pkg::ST_IDLE) && s_next.rec_ok;
    // system reset drives the flash reset pin low
    if (rst) begin
      s_next            = '0;
      s_next.state      = bfb_pkg::ST_RST_LOW;
      s_next.ce_n       = 1'b1;
      s_next.oe_n       = 1'b1;
      s_next.we_n       = 1'b1;
      s_next.rec_wait   = 1'b1;
      s_next.array_mode = 1'b1;
    end
  end

  always_ff @(posedge clk_sys) begin
    s_reg <= s_next;
  end

  // outputs straight from the state record
  assign done              = s_reg.done;
  assign rdata             = s_reg.rdata;
  assign idle              = s_reg.idle;
  assign busy              = s_reg.busy;
  assign reset_powerdown_n = s_reg.rp_n;
  assign ce_n              = s_reg.ce_n;
  assign oe_n              = s_reg.oe_n;
  assign we_n              = s_reg.we_n;
  assign wp_n              = s_reg.wp_n;
  assign a_out             = s_reg.a_out;
  assign dq_out            = s_reg.dq_out;
  assign dq_oe             = s_reg.dq_oe;

  // ----------------------------------------------------------------
  // checks: cycles since release and since shutdown end
  // ----------------------------------------------------------------
  logic [11:0] since_rise_reg;
  logic [11:0] since_abrt_reg;
  logic        rp_d_reg;
  logic        ab_d_reg;

  always_ff @(posedge clk_sys) begin
    rp_d_reg <= s_reg.rp_n;
    ab_d_reg <= s_reg.aborting;
    if (rst || (s_reg.rp_n && !rp_d_reg)) begin
      since_rise_reg <= 12'h000;
    end else if (since_rise_reg != bfb_pkg::CNT_MAX) begin
      since_rise_reg <= since_rise_reg + 12'h001;
    end
    if (rst) begin
      since_abrt_reg <= bfb_pkg::CNT_MAX;
    end else if (!s_reg.aborting && ab_d_reg) begin
      since_abrt_reg <= 12'h000;
    end else if (since_abrt_reg != bfb_pkg::CNT_MAX) begin
      since_abrt_reg <= since_abrt_reg + 12'h001;
    end
  end

  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);

  sequence read_strobe_s;
    $fell(oe_n);
  endsequence
  sequence array_read_s;
    $fell(oe_n) && s_reg.op == bfb_pkg::OP_READ;
  endsequence

  AST_READ_STROBES: assert property (!oe_n |-> !ce_n && we_n && reset_powerdown_n && !dq_oe)
    else $error("read strobe with wrong control levels");
  AST_READ_HOLDS: assert property (read_strobe_s |-> (!oe_n && !ce_n) [*3])
    else $error("read strobe too short");
  AST_WRITE_STROBES: assert property (!we_n |-> !ce_n && oe_n && dq_oe && reset_powerdown_n)
    else $error("write strobe with wrong control levels");
  AST_READ_RECOVERY: assert property (read_strobe_s |-> since_rise_reg >= bfb_pkg::RD_REC_CYC)
    else $error("read too soon after reset release");
  AST_WRITE_RECOVERY: assert property ($fell(we_n) |-> since_rise_reg >= bfb_pkg::WR_REC_CYC)
    else $error("write too soon after reset release");
  AST_ABORT_RECOVERY: assert property (read_strobe_s |-> since_abrt_reg >= bfb_pkg::RD_REC_CYC)
    else $error("read too soon after abort shutdown");
  AST_WP_FOR_ALTER: assert property ($rose(we_n) && s_reg.second &&
      (s_reg.op == bfb_pkg::OP_PROGRAM || s_reg.op == bfb_pkg::OP_ERASE) |-> wp_n ##1 wp_n)
    else $error("write protect low during program or erase");
  AST_RP_FOLLOWS_RESET: assert property ($fell(rst) |-> !reset_powerdown_n)
    else $error("reset pin not low after system reset");
  AST_ARRAY_BEFORE_READ: assert property (array_read_s |-> s_reg.array_mode)
    else $error("array read without read array command");

endmodule
`default_nettype wire

// >>> bfb_flash_model.sv
/*
  behavioural word-wide boot flash standing on the controller's pins.
  assumes clean host strobes; dq is resolved here from the host enable.
*/
`timescale 1ns/100ps
`default_nettype none
module bfb_flash_model #(
  parameter int          BUSY_NS    = 2000,      // internal operation time, plain default
  parameter bit          SUPPLY_LOW = 1'b0,      // program supply below lockout
  parameter logic [15:0] MFR_CODE   = 16'h00C3,  // maker code, value arbitrary
  parameter logic [15:0] DEV_CODE   = 16'h3C51   // part code, value arbitrary
) (
  input  wire logic        reset_powerdown_n,
  input  wire logic        ce_n,
  input  wire logic        oe_n,
  input  wire logic        we_n,
  input  wire logic        wp_n,
  input  wire logic [20:0] a,
  input  wire logic [15:0] dq_host,
  input  wire logic        dq_oe,
  output logic      [15:0] dq  // word-wide part, all sixteen lines
);
  logic [15:0] mem [int];     // programmed words
  bit          ers [int];     // erased blocks, parameter and main
  logic        st_mode = 0;   // status shown instead of array
  int          setup_sel = 0; // 1 program, 2 erase set-up pending
  logic        ready = 1;     // internal sequence finished
  logic [15:0] last = 0;      // last value driven
  logic [15:0] rd_val;        // value for a read
  wire         drv = reset_powerdown_n && !ce_n && !oe_n && we_n;
  logic        id_mode = 0;   // identifier codes shown instead of array
  logic        lock_fail = 0; // status bit 1
  logic        prg_fail = 0;  // status bit 4
  logic        ers_fail = 0;  // status bit 5
  // block number: eight 4096-word parameter blocks, then 32768-word main blocks
  function automatic int blk(input logic [20:0] x);
    return (x < 21'h00_8000) ? int'(x[14:12]) : 7 + int'(x[20:15]);
  endfunction
  // --------------------------------------------------------------
  // read path; released pins show the inverse of the last value
  // --------------------------------------------------------------
  always @* begin
    if (st_mode) rd_val = {8'h00, ready, 1'b0, ers_fail, prg_fail, 2'b00, lock_fail, 1'b0};
    else if (id_mode && a[20:1] == 20'h0_0000) rd_val = a[0] ? DEV_CODE : MFR_CODE;
    else if (mem.exists(int'(a))) rd_val = mem[int'(a)];
    else if (ers.exists(blk(a))) rd_val = 16'hFFFF;
    else rd_val = ~a[15:0];
    dq = dq_oe ? dq_host : (drv ? rd_val : ~last);
  end
  always @(negedge drv) last = rd_val;
  // internal sequence: status mode, ready low until the timer runs out
  task automatic start_op();
    setup_sel = 0;
    st_mode = 1;
    id_mode = 0;
    ready = 0;
    // runs on whatever chip select does meanwhile
    fork
      #(BUSY_NS) ready = 1;
    join_none
  endtask
  // command latch on write enable rise, at any address
  always @(posedge we_n) begin
    if (reset_powerdown_n && !ce_n && oe_n) begin
      if (setup_sel == 1) begin
        if (!wp_n && blk(a) < 2) begin
          lock_fail = 1;
          prg_fail = 1;
        end else if (!SUPPLY_LOW) begin
          mem[int'(a)] = dq_host;
        end
        start_op();
      end else if (setup_sel == 2 && dq_host[7:0] == 8'hD0) begin
        if (!wp_n && blk(a) < 2) begin
          lock_fail = 1;
          ers_fail = 1;
        end else if (!SUPPLY_LOW) begin
          mem.delete(int'(a));
          ers[blk(a)] = 1;
        end
        start_op();
      end else begin
        setup_sel = (dq_host[7:0] == 8'h40) ? 1 : (dq_host[7:0] == 8'h20) ? 2 : 0;
        id_mode = (dq_host[7:0] == 8'h90);
        st_mode = (dq_host[7:0] != 8'hFF) && (dq_host[7:0] != 8'h90);
      end
    end
  end
  // reset aborts any sequence and returns to array mode
  always @(negedge reset_powerdown_n) begin
    st_mode = 0;
    setup_sel = 0;
    ready = 1;
    id_mode = 0;
    lock_fail = 0;
    prg_fail = 0;
    ers_fail = 0;
  end
endmodule
`default_nettype wire

// >>> tb_top.sv
/*
  self-checking bench of the boot flash host controller.
  assumes the flash model answers on the pins; 40 MHz clock.
*/
`timescale 1ns/100ps
`default_nettype none
`define CHK(NM, E, G) begin n_tests++; if ((G) !== (E)) begin error_cnt++; $display("FAIL %s exp %h got %h", NM, E, G); end end
module tb_top;
  logic clk_sys = 0;
  logic rst = 1;
  logic req = 0;
  bfb_pkg::bfb_op_type op = bfb_pkg::OP_READ;
  logic [20:0] addr = 0;
  logic [15:0] wdata = 0;
  logic done, idle, busy, reset_powerdown_n, ce_n, oe_n, we_n, wp_n, dq_oe;
  logic [15:0] rdata, dq_out, dq;
  logic [20:0] a_out;
  int error_cnt = 0;
  int n_tests = 0;
  always #12.5 clk_sys = ~clk_sys;
  bfb_ctrl bfb_ctrl_inst (.clk_sys(clk_sys), .rst(rst), .req(req), .op(op), .addr(addr), .wdata(wdata),
    .done(done), .rdata(rdata), .idle(idle), .busy(busy), .reset_powerdown_n(reset_powerdown_n),
    .ce_n(ce_n), .oe_n(oe_n), .we_n(we_n), .wp_n(wp_n), .a_out(a_out), .dq_out(dq_out),
    .dq_oe(dq_oe), .dq_in(dq));
  bfb_flash_model bfb_flash_model_inst (.reset_powerdown_n(reset_powerdown_n), .ce_n(ce_n), .oe_n(oe_n),
    .we_n(we_n), .wp_n(wp_n), .a(a_out), .dq_host(dq_out), .dq_oe(dq_oe), .dq(dq));
  // --------------------------------------------------------------
  // shared request task: hold req until done, bounded wait
  // --------------------------------------------------------------
  task automatic run(input bfb_pkg::bfb_op_type o, input logic [20:0] a, input logic [15:0] d);
    int k;
    op = o;
    addr = a;
    wdata = d;
    req = 1;
    for (k = 0; k < 2000 && done !== 1'b1; k++) begin
      @(posedge clk_sys);
      #1;
    end
    req = 0;
    `CHK("done", 1'b1, done)
    // let an edge pass so the next request never meets this release
    @(posedge clk_sys);
    #1;
  endtask
  task automatic t_reset();
    @(posedge clk_sys);
    #1;
    `CHK("rp", 1'b0, reset_powerdown_n)
    `CHK("pins", 3'b100, {ce_n, wp_n, dq_oe})
    `CHK("quiet", 5'b11000, {oe_n, we_n, done, idle, busy})
    repeat (4) @(posedge clk_sys);
    #1 rst = 0;
  endtask
  task automatic t_cmd();
    run(bfb_pkg::OP_READ, 21'h1_2345, 16'h0000);
    `CHK("first read", 16'hDCBA, rdata)
    `CHK("idle", 1'b1, idle)
    run(bfb_pkg::OP_COMMAND, 21'h1F_FFFF, 16'h0070);
    run(bfb_pkg::OP_STATUS, 21'h0_0000, 16'h0000);
    `CHK("cmd any addr", 16'h0080, rdata)
    run(bfb_pkg::OP_COMMAND, 21'h0_0000, 16'h0090);
    run(bfb_pkg::OP_STATUS, 21'h0_0001, 16'h0000);
    `CHK("ident", 16'h3C51, rdata)
    run(bfb_pkg::OP_COMMAND, 21'h0_0000, 16'h00FF);
    run(bfb_pkg::OP_STATUS, 21'h0_0010, 16'h0000);
    `CHK("array mode", 16'hFFEF, rdata)
  endtask
  task automatic t_prog();
    run(bfb_pkg::OP_PROGRAM, 21'h0_0100, 16'h5A5A);
    `CHK("busy wp", 2'b11, {busy, wp_n})
    run(bfb_pkg::OP_STATUS, 21'h0_0100, 16'h0000);
    `CHK("status busy", 16'h0000, rdata)
    repeat (100) @(posedge clk_sys);
    #1;
    run(bfb_pkg::OP_STATUS, 21'h0_0100, 16'h0000);
    `CHK("ready", 17'h0_0080, {busy, rdata})
    run(bfb_pkg::OP_READ, 21'h0_0100, 16'h0000);
    `CHK("programmed", 16'h5A5A, rdata)
  endtask
  task automatic t_erase();
    run(bfb_pkg::OP_ERASE, 21'h0_0100, 16'h0000);
    repeat (100) @(posedge clk_sys);
    #1;
    run(bfb_pkg::OP_STATUS, 21'h0_0100, 16'h0000);
    `CHK("erase ready", 16'h0080, rdata)
    run(bfb_pkg::OP_READ, 21'h0_0100, 16'h0000);
    `CHK("erased", 16'hFFFF, rdata)
    run(bfb_pkg::OP_READ, 21'h0_0FFF, 16'h0000);
    `CHK("param block end", 16'hFFFF, rdata)
    run(bfb_pkg::OP_READ, 21'h0_1100, 16'h0000);
    `CHK("next param block", 16'hEEFF, rdata)
    run(bfb_pkg::OP_ERASE, 21'h1_0000, 16'h0000);
    repeat (100) @(posedge clk_sys);
    #1;
    run(bfb_pkg::OP_READ, 21'h1_7FFF, 16'h0000);
    `CHK("main block end", 16'hFFFF, rdata)
    run(bfb_pkg::OP_READ, 21'h1_8000, 16'h0000);
    `CHK("next main block", 16'h7FFF, rdata)
  endtask
  // reset in mid-program: abort, then array reads again
  task automatic t_abort();
    run(bfb_pkg::OP_PROGRAM, 21'h0_0200, 16'h1234);
    run(bfb_pkg::OP_RESET, 21'h0_0000, 16'h0000);
    `CHK("abort rp", 2'b00, {reset_powerdown_n, busy})
    run(bfb_pkg::OP_READ, 21'h0_2300, 16'h0000);
    `CHK("after abort", 16'hDCFF, rdata)
  endtask
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  initial begin
    #1;
    t_reset();
    t_cmd();
    t_prog();
    t_erase();
    t_abort();
    tally_and_finish();
  end
  initial begin
    #500_000;
    error_cnt++;
    tally_and_finish();
  end
endmodule
`default_nettype wire
